// File: dv/io_ctrl_model.sv
// register-bus master model of the input/output controller
`include "diag_alarm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module io_ctrl_model (
  // clock
  input wire logic mclk,
  // register port
  output var logic [7:0] addr,
  output var logic [31:0] wdata,
  output var logic wr,
  output var logic rd,
  input wire logic [31:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // ****************************************
  // bus cycles
  // ****************************************
  // a released bus shows the inverse of its last value
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask

  task automatic ack_irq(input int slow);
    repeat (slow) @(posedge mclk);
    wr_reg(`REG_HW_STAT, 32'h0000_0001 << `HW_ACK_BIT);
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench of the diagnostic and alarm unit
`include "diag_alarm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import diag_alarm_pkg::*;
;
  localparam int HALF = 4;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] din = 8'h00, volt_low = 8'h00, short_gnd = 8'h00, wire_open = 8'h00;
  logic field_supply_ok = 1'b1, backplane_ok = 1'b0, fw_update = 1'b0;
  logic [7:0] addr, diag_code, chan_status_led, chan_error_led;
  logic [31:0] wdata, rdata, v;
  logic wr, rd, hw_irq, diag_alarm, diag_led, supply_indicator, lvl;
  int bad_count = 0, n_checks = 0, n;
  logic [7:0] codes [4] = '{`CODE_WIRE_BREAK, `CODE_PARAM_ERR, `CODE_SUPPLY, `CODE_UNAVAIL};
  logic [5:0] bits [4] = '{6'h02, 6'h04, 6'h08, 6'h20};

  always #12.5 mclk = ~mclk;

  digital_input_diag_alarm_unit #(.CH(8), .BLINK_CYCLES(HALF)) u_digital_input_diag_alarm_unit (
    .mclk, .rst_b, .din, .volt_low, .short_gnd, .wire_open, .field_supply_ok,
    .backplane_ok, .fw_update, .addr, .wdata, .wr, .rd, .rdata, .hw_irq,
    .diag_alarm, .diag_code, .diag_led, .chan_status_led, .chan_error_led,
    .supply_indicator
  );

  io_ctrl_model u_io_ctrl_model (.mclk, .addr, .wdata, .wr, .rd, .rdata);

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    chk_word({24'h0, got}, {24'h0, exp});
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // pin changes need up to seven edges to reach the outputs
  task automatic settle;
    repeat (8) @(posedge mclk);
    #1;
  endtask

  // counts indicator changes over two full flash periods
  task automatic flash(output int cnt, output logic last);
    logic prev;
    cnt = 0;
    @(posedge mclk);
    #1;
    prev = diag_led;
    repeat (4 * HALF) begin
      @(posedge mclk);
      #1;
      cnt += (diag_led !== prev);
      prev = diag_led;
    end
    last = prev;
  endtask

  task automatic cause(input int i, input logic on);
    @(posedge mclk);
    case (i)
      0: wire_open <= on ? 8'h08 : 8'h00;
      1: u_io_ctrl_model.wr_reg(`REG_CHAN_EN, on ? 32'h0000_00F7 : 32'h0000_00FF);
      2: field_supply_ok <= ~on;
      default: fw_update <= on;
    endcase
  endtask

  task automatic clear_diag;
    u_io_ctrl_model.wr_reg(`REG_DIAG_STAT, 32'h0000_003F);
    settle;
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 25);
    bad_count++;
    finish_test;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk_out({4'h0, diag_led, hw_irq, diag_alarm, supply_indicator}, 8'h00);
    u_io_ctrl_model.rd_reg(`REG_CTRL, v);
    chk_word(v, 32'h0000_0000);
    flash(n, lvl);
    chk_word(n, 32'h0);
    chk_bit(lvl, 1'b0);
    @(posedge mclk);
    backplane_ok <= 1'b1;
    settle;
    flash(n, lvl);
    chk_word(n, 32'h4);
    chk_bit(supply_indicator, 1'b1);
    u_io_ctrl_model.wr_reg(`REG_CTRL, 32'h1);
    u_io_ctrl_model.wr_reg(`REG_CHAN_EN, 32'hFF);
    // drop the supply event latched while the pins were still syncing
    clear_diag;
    flash(n, lvl);
    chk_word(n, 32'h0);
    chk_bit(lvl, 1'b1);
    u_io_ctrl_model.wr_reg(`REG_DIAG_EN, 32'h08);
    @(posedge mclk);
    din <= 8'h02;
    volt_low <= 8'h04;
    short_gnd <= 8'h08;
    settle;
    chk_out(chan_status_led, 8'h0A);
    chk_out(chan_error_led, 8'h0C);
    chk_out(diag_code, `CODE_SHORT);
    chk_bit(diag_alarm, 1'b1);
    u_io_ctrl_model.rd_reg(`REG_DIAG_STAT, v);
    chk_word(v, 32'h0008_0101);
    flash(n, lvl);
    chk_word(n, 32'h4);
    @(posedge mclk);
    field_supply_ok <= 1'b0;
    settle;
    chk_out(chan_status_led, 8'hFF);
    chk_out(chan_error_led, 8'h08);
    chk_bit(supply_indicator, 1'b0);
    @(posedge mclk);
    field_supply_ok <= 1'b1;
    din <= 8'h00;
    volt_low <= 8'h00;
    short_gnd <= 8'h00;
    settle;
    clear_diag;
    chk_out(diag_code, `CODE_NONE);
    for (int i = 0; i < 4; i++) begin
      cause(i, 1'b1);
      settle;
      chk_out(diag_code, codes[i]);
      u_io_ctrl_model.rd_reg(`REG_DIAG_STAT, v);
      chk_word(v & 32'h3F, {26'h0, bits[i]});
      cause(i, 1'b0);
      settle;
      clear_diag;
      chk_bit(diag_alarm, 1'b0);
    end
    // input freeze while firmware is updated
    @(posedge mclk);
    din <= 8'h0F;
    settle;
    @(posedge mclk);
    fw_update <= 1'b1;
    settle;
    @(posedge mclk);
    din <= 8'hF0;
    settle;
    u_io_ctrl_model.rd_reg(`REG_PROC_IN, v);
    chk_word(v, 32'h0F);
    @(posedge mclk);
    din <= 8'h00;
    settle;
    @(posedge mclk);
    fw_update <= 1'b0;
    settle;
    clear_diag;
    // edges on the outermost channels, prompt and slow acknowledge
    u_io_ctrl_model.wr_reg(`REG_EDGE_EN, 32'h8181);
    for (int c = 0; c < 8; c += 7) begin
      for (int p = 1; p >= 0; p--) begin
        @(posedge mclk);
        din <= p ? 8'h01 << c : 8'h00;
        settle;
        chk_bit(hw_irq, 1'b1);
        u_io_ctrl_model.rd_reg(`REG_HW_REC, v);
        chk_word(v, {`RECORD_ID, 8'(c), p ? `EVT_RISE : `EVT_FALL});
        u_io_ctrl_model.ack_irq(5 * p);
        @(posedge mclk);
        #1;
        chk_bit(hw_irq, 1'b0);
      end
    end
    // second edge before acknowledge is lost
    @(posedge mclk);
    din <= 8'h01;
    settle;
    @(posedge mclk);
    din <= 8'h81;
    settle;
    u_io_ctrl_model.rd_reg(`REG_HW_STAT, v);
    chk_word(v, 32'h3);
    u_io_ctrl_model.rd_reg(`REG_HW_REC, v);
    chk_word(v, {`RECORD_ID, 8'h00, `EVT_RISE});
    chk_out(diag_code, `CODE_HW_LOST);
    u_io_ctrl_model.ack_irq(0);
    clear_diag;
    u_io_ctrl_model.rd_reg(`REG_HW_STAT, v);
    chk_word(v, 32'h2);
    chk_out(diag_code, `CODE_HW_LOST);
    u_io_ctrl_model.wr_reg(`REG_CTRL, 32'h1);
    clear_diag;
    u_io_ctrl_model.rd_reg(`REG_HW_STAT, v);
    chk_word(v, 32'h0);
    chk_out(diag_code, `CODE_NONE);
    // unmapped and read-only places
    u_io_ctrl_model.rd_reg(8'h20, v);
    chk_word(v, 32'h0);
    u_io_ctrl_model.wr_reg(8'h20, 32'h0);
    u_io_ctrl_model.wr_reg(`REG_PROC_IN, 32'hFFFF_FFFF);
    u_io_ctrl_model.rd_reg(`REG_CTRL, v);
    chk_word(v, 32'h1);
    u_io_ctrl_model.rd_reg(`REG_PROC_IN, v);
    chk_word(v, 32'h81);
    // two channels in one cycle: lowest kept, lost set
    @(posedge mclk);
    din <= 8'h00;
    settle;
    u_io_ctrl_model.rd_reg(`REG_HW_REC, v);
    chk_word(v, {`RECORD_ID, 8'h00, `EVT_FALL});
    u_io_ctrl_model.rd_reg(`REG_HW_STAT, v);
    chk_word(v, 32'h3);
    @(posedge mclk);
    #1;
    chk_word(rdata, 32'h0);
    finish_test;
  end
endmodule
`default_nettype wire

// File: logic/blink_gen.sv
// free-running flash source for the indicators
`timescale 1ns/100ps
`default_nettype none
module blink_gen #(
  parameter int HALF_CYCLES = 10000000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // flash level
  output var logic blink
);
  logic [31:0] cnt_q;

  // (R23) one toggle period
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0;
      blink <= 1'b0;
    end else if (cnt_q == 32'(HALF_CYCLES - 1)) begin
      cnt_q <= 32'h0;
      blink <= ~blink;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule
`default_nettype wire

// File: logic/diag_alarm_defines.svh
// offsets, field positions, codes and timing figures of the diagnostic and alarm unit
`ifndef DIAG_ALARM_DEFINES_SVH
`define DIAG_ALARM_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define REG_CTRL 8'h00
`define REG_CHAN_EN 8'h04
`define REG_DIAG_EN 8'h08
`define REG_EDGE_EN 8'h0C
`define REG_PROC_IN 8'h10
`define REG_HW_REC 8'h14
`define REG_HW_STAT 8'h18
`define REG_DIAG_STAT 8'h1C

// ****************************************
// field positions
// ****************************************
`define CTRL_PARAMS_BIT 0
`define HW_ACK_BIT 0
`define HW_LOST_BIT 1
`define EDGE_FALL_LSB 8
`define DIAG_CODE_LSB 8
`define DIAG_CH_LSB 16

// ****************************************
// record and event codes
// ****************************************
`define RECORD_ID 16'h0001
`define EVT_RISE 8'h01
`define EVT_FALL 8'h02
`define CODE_SHORT 8'h01
`define CODE_WIRE_BREAK 8'h06
`define CODE_PARAM_ERR 8'h10
`define CODE_SUPPLY 8'h11
`define CODE_HW_LOST 8'h16
`define CODE_UNAVAIL 8'h1F
`define CODE_NONE 8'h00

// ****************************************
// timing
// ****************************************
`define CLK_KHZ 40000
`define BLINK_HALF_MS 250

`endif

// File: logic/diag_alarm_pkg.sv
// types shared by the diagnostic and alarm unit
package diag_alarm_pkg;

  typedef struct packed {
    logic [15:0] id;
    logic [7:0] chan;
    logic [7:0] evt;
  } hw_record_t;

  typedef struct packed {
    logic unavail;
    logic hw_lost;
    logic supply;
    logic param_err;
    logic wire_break;
    logic short_gnd;
  } diag_events_t;

  typedef enum logic [1:0] {LED_DARK, LED_FLASH, LED_STEADY} led_mode_t;

endpackage

// File: logic/digital_input_diag_alarm_unit.sv
// status indication, diagnostic alarm and edge interrupt logic of an eight-channel input
//
// Summary of operation
// (R1) module indicator off while the backplane supply is bad
// (R2) module indicator flashes while no parameters are assigned
// (R3) module indicator steady when assigned and no diagnostic pending
// (R4) module indicator flashes when assigned and a diagnostic is pending
// (R5) both channel indicators off when deactivated or input is 0; a deactivated channel still lights status or error from its pins
// (R6) status only when voltage above 11 V or no supply
// (R7) error only when supply present and voltage below 11 V
// (R8) both channel indicators on when active with a recognised diagnostic
// (R9) supply indicator follows the field supply
// (R10) diagnostic events: short, wire break, parameters, supply, lost, unavailable
// (R11) hardware interrupt on rising and on falling input edges
// (R12) record opens with a 16-bit structure id of 0001
// (R13) then one byte with the channel number 0 to 7
// (R14) then one event byte: 01 rising, 02 falling
// (R15) every diagnostic event raises an alarm with a readable code
// (R16) short circuit reported with code 01
// (R17) wire break reported with code 06
// (R18) parameter error reported with code 10
// (R19) missing field supply reported with code 11
// (R20) unacknowledged interrupt blocks a new one and reports code 16
// (R21) lost interrupt condition stays until new parameters are assigned
// (R22) during firmware update inputs freeze and code 1F is reported
// (R23) all flashing uses one configurable toggle period
`include "diag_alarm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module digital_input_diag_alarm_unit
  import diag_alarm_pkg::*;
#(
  parameter int CH = 8,
  parameter int BLINK_CYCLES = `BLINK_HALF_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // field pins
  input wire logic [CH-1:0] din,
  input wire logic [CH-1:0] volt_low,
  input wire logic [CH-1:0] short_gnd,
  input wire logic [CH-1:0] wire_open,
  input wire logic field_supply_ok,
  input wire logic backplane_ok,
  input wire logic fw_update,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output var logic [31:0] rdata,
  // alarms to the controller
  output var logic hw_irq,
  output var logic diag_alarm,
  output var logic [7:0] diag_code,
  // indicators
  output var logic diag_led,
  output var logic [CH-1:0] chan_status_led,
  output var logic [CH-1:0] chan_error_led,
  output var logic supply_indicator
);

  // ****************************************
  // synchronised pins
  // ****************************************
  localparam int SW = 4 * CH + 3;
  logic [SW-1:0] sync_v;
  logic [CH-1:0] din_s;
  logic [CH-1:0] vlow_s;
  logic [CH-1:0] short_s;
  logic [CH-1:0] wopen_s;
  logic field_ok_s;
  logic bp_ok_s;
  logic fw_s;
  logic blink;

  input_sync #(.W(SW)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in({fw_update, backplane_ok, field_supply_ok, wire_open, short_gnd, volt_low, din}),
    .sync_out(sync_v)
  );

  assign {fw_s, bp_ok_s, field_ok_s, wopen_s, short_s, vlow_s, din_s} = sync_v;

  blink_gen #(.HALF_CYCLES(BLINK_CYCLES)) u_blink (
    .mclk(mclk),
    .rst_b(rst_b),
    .blink(blink)
  );

  // ****************************************
  // software registers
  // ****************************************
  logic params_q;
  logic [CH-1:0] chan_en_q;
  logic [CH-1:0] diag_en_q;
  logic [CH-1:0] rise_en_q;
  logic [CH-1:0] fall_en_q;
  logic new_params;
  logic hw_ack;
  logic [5:0] diag_clr;

  assign new_params = wr && (addr == `REG_CTRL) && wdata[`CTRL_PARAMS_BIT];
  assign hw_ack = wr && (addr == `REG_HW_STAT) && wdata[`HW_ACK_BIT];
  assign diag_clr = (wr && (addr == `REG_DIAG_STAT)) ? wdata[5:0] : 6'h00;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      params_q <= 1'b0;
      chan_en_q <= '0;
      diag_en_q <= '0;
      rise_en_q <= '0;
      fall_en_q <= '0;
    end else if (wr) begin
      if (addr == `REG_CTRL) begin
        params_q <= wdata[`CTRL_PARAMS_BIT];
      end else if (addr == `REG_CHAN_EN) begin
        chan_en_q <= wdata[CH-1:0];
      end else if (addr == `REG_DIAG_EN) begin
        diag_en_q <= wdata[CH-1:0];
      end else if (addr == `REG_EDGE_EN) begin
        rise_en_q <= wdata[CH-1:0];
        fall_en_q <= wdata[`EDGE_FALL_LSB +: CH];
      end
    end
  end

  // ****************************************
  // process values and edges
  // ****************************************
  logic [CH-1:0] proc_q;
  logic [CH-1:0] rise;
  logic [CH-1:0] fall;
  logic [CH-1:0] hits;

  // (R22) inputs frozen during update
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      proc_q <= '0;
    end else if (!fw_s) begin
      proc_q <= din_s;
    end
  end

  // (R11) rising and falling edges
  assign rise = fw_s ? '0 : (din_s & ~proc_q);
  assign fall = fw_s ? '0 : (~din_s & proc_q);
  assign hits = chan_en_q & {CH{params_q}} & ((rise & rise_en_q) | (fall & fall_en_q));

  // ****************************************
  // hardware interrupt record
  // ****************************************
  logic edge_hit;
  logic multi_hit;
  logic [7:0] hit_chan;
  logic hit_rise;
  hw_record_t rec_q;
  logic hw_pend_q;
  logic lost_q;

  assign edge_hit = |hits;
  assign multi_hit = |(hits & (hits - CH'(1)));

  always_comb begin
    hit_chan = 8'h00;
    hit_rise = 1'b0;
    for (int i = CH - 1; i >= 0; i--) begin
      if (hits[i]) begin
        hit_chan = 8'(i);
        hit_rise = rise[i];
      end
    end
  end

  // (R12) id, channel and event captured together
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rec_q <= '0;
      hw_pend_q <= 1'b0;
    end else if (edge_hit && (!hw_pend_q || hw_ack)) begin
      rec_q.id <= `RECORD_ID;
      // (R13) channel byte
      rec_q.chan <= hit_chan;
      // (R14) event byte
      rec_q.evt <= hit_rise ? `EVT_RISE : `EVT_FALL;
      hw_pend_q <= 1'b1;
    end else if (hw_ack) begin
      hw_pend_q <= 1'b0;
    end
  end

  assign hw_irq = hw_pend_q;

  // (R20) blocked interrupt sets the lost flag
  // (R21) cleared only by new parameters
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lost_q <= 1'b0;
    end else if ((edge_hit && hw_pend_q && !hw_ack) || multi_hit) begin
      lost_q <= 1'b1;
    end else if (new_params) begin
      lost_q <= 1'b0;
    end
  end

  // ****************************************
  // diagnostic alarms
  // ****************************************
  diag_events_t cond;
  diag_events_t sticky_q;
  logic diag_pend;
  logic [7:0] code_d;
  logic [7:0] diag_ch_q;

  // (R10) diagnostic event sources
  always_comb begin
    cond.short_gnd = |(short_s & chan_en_q);
    cond.wire_break = |(wopen_s & chan_en_q & diag_en_q);
    cond.param_err = params_q && |((rise_en_q | fall_en_q | diag_en_q) & ~chan_en_q);
    cond.supply = !field_ok_s;
    cond.hw_lost = lost_q;
    cond.unavail = fw_s;
  end

  // (R15) sticky events, a new event wins over the clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sticky_q <= '0;
      diag_ch_q <= 8'h00;
    end else begin
      sticky_q <= (sticky_q & ~diag_clr) | cond;
      diag_ch_q <= (diag_ch_q & ~{8{diag_clr[0] | diag_clr[1]}}) | 8'(short_s | wopen_s);
    end
  end

  assign diag_pend = (|sticky_q) || (|cond);

  always_comb begin
    code_d = `CODE_NONE;
    if (sticky_q.short_gnd) begin
      // (R16) short circuit
      code_d = `CODE_SHORT;
    end else if (sticky_q.wire_break) begin
      // (R17) wire break
      code_d = `CODE_WIRE_BREAK;
    end else if (sticky_q.param_err) begin
      // (R18) parameter error
      code_d = `CODE_PARAM_ERR;
    end else if (sticky_q.supply) begin
      // (R19) missing supply
      code_d = `CODE_SUPPLY;
    end else if (sticky_q.hw_lost) begin
      // (R20) lost interrupt
      code_d = `CODE_HW_LOST;
    end else if (sticky_q.unavail) begin
      // (R22) firmware update
      code_d = `CODE_UNAVAIL;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      diag_code <= `CODE_NONE;
      diag_alarm <= 1'b0;
    end else begin
      diag_code <= code_d;
      diag_alarm <= |sticky_q;
    end
  end

  // ****************************************
  // indicators
  // ****************************************
  led_mode_t mod_mode;

  always_comb begin
    if (!bp_ok_s) begin
      // (R1) dark without backplane supply
      mod_mode = LED_DARK;
    end else if (!params_q) begin
      // (R2) not ready
      mod_mode = LED_FLASH;
    end else if (!diag_pend) begin
      // (R3) running clean
      mod_mode = LED_STEADY;
    end else begin
      // (R4) diagnostic pending
      mod_mode = LED_FLASH;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      diag_led <= 1'b0;
      supply_indicator <= 1'b0;
    end else begin
      case (mod_mode)
        LED_DARK: diag_led <= 1'b0;
        LED_FLASH: diag_led <= blink;
        default: diag_led <= 1'b1;
      endcase
      // (R9) supply indicator
      supply_indicator <= field_ok_s;
    end
  end

  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : g_chan
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          chan_status_led[c] <= 1'b0;
          chan_error_led[c] <= 1'b0;
        end else if (chan_en_q[c] && diag_en_q[c] && (short_s[c] || wopen_s[c])) begin
          // (R8) active with recognised diagnostic
          chan_status_led[c] <= 1'b1;
          chan_error_led[c] <= 1'b1;
        end else if (!field_ok_s) begin
          // (R6) no supply
          chan_status_led[c] <= 1'b1;
          chan_error_led[c] <= 1'b0;
        end else if (vlow_s[c]) begin
          // (R7) supply present, voltage low
          chan_status_led[c] <= 1'b0;
          chan_error_led[c] <= 1'b1;
        end else if (din_s[c]) begin
          // (R6) voltage above threshold
          chan_status_led[c] <= 1'b1;
          chan_error_led[c] <= 1'b0;
        end else begin
          // (R5) off
          chan_status_led[c] <= 1'b0;
          chan_error_led[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h0;
    end else if (!rd) begin
      rdata <= 32'h0;
    end else if (addr == `REG_CTRL) begin
      rdata <= 32'(params_q);
    end else if (addr == `REG_CHAN_EN) begin
      rdata <= 32'(chan_en_q);
    end else if (addr == `REG_DIAG_EN) begin
      rdata <= 32'(diag_en_q);
    end else if (addr == `REG_EDGE_EN) begin
      rdata <= 32'(rise_en_q) | (32'(fall_en_q) << `EDGE_FALL_LSB);
    end else if (addr == `REG_PROC_IN) begin
      rdata <= 32'(proc_q);
    end else if (addr == `REG_HW_REC) begin
      rdata <= rec_q;
    end else if (addr == `REG_HW_STAT) begin
      rdata <= 32'({lost_q, hw_pend_q});
    end else if (addr == `REG_DIAG_STAT) begin
      rdata <= 32'(sticky_q) | (32'(code_d) << `DIAG_CODE_LSB)
               | (32'(diag_ch_q) << `DIAG_CH_LSB);
    end else begin
      rdata <= 32'h0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  led_dark_a: assert property (!bp_ok_s |=> !diag_led) // (R1)
    else $error("module indicator lit without backplane supply");
  led_unready_a: assert property (bp_ok_s && !params_q |=> diag_led == $past(blink)) // (R2)
    else $error("module indicator not flashing while unassigned");
  led_steady_a: assert property (bp_ok_s && params_q && !diag_pend |=> diag_led) // (R3)
    else $error("module indicator not steady");
  led_diag_a: assert property (bp_ok_s && params_q && diag_pend |=> diag_led == $past(blink)) // (R4)
    else $error("module indicator not flashing on diagnostic");
  supply_led_a: assert property (##1 supply_indicator == $past(field_ok_s)) // (R9)
    else $error("supply indicator wrong");
  record_id_a: assert property ($rose(hw_irq) |-> rec_q.id == `RECORD_ID // (R12)
                                && rec_q.chan < 8'(CH))
    else $error("bad interrupt record id or channel");
  record_evt_a: assert property (edge_hit && !hw_pend_q |=> rec_q.evt == // (R14)
                                 ($past(hit_rise) ? `EVT_RISE : `EVT_FALL))
    else $error("bad interrupt event byte");
  lost_set_a: assert property (edge_hit && hw_pend_q && !hw_ack |=> lost_q ##1 (lost_q || $past(new_params))) // (R20)
    else $error("lost interrupt not flagged");
  lost_hold_a: assert property (lost_q && !new_params |=> lost_q) // (R21)
    else $error("lost flag dropped without new parameters");
  fw_freeze_a: assert property (fw_s |=> $stable(proc_q) && !hw_irq || $past(hw_pend_q)) // (R22)
    else $error("inputs or interrupt moved during update");
  short_code_a: assert property (sticky_q.short_gnd |=> diag_code == `CODE_SHORT) // (R16)
    else $error("short circuit code wrong");
  supply_code_a: assert property (sticky_q == 6'h08 |=> diag_code == `CODE_SUPPLY && diag_alarm) // (R19)
    else $error("supply code wrong");
  chan_err_a: assert property (field_ok_s && |(vlow_s & ~(chan_en_q & diag_en_q)) // (R7)
                               |=> &((chan_error_led & ~chan_status_led)
                                     | ~$past(vlow_s & ~(chan_en_q & diag_en_q))))
    else $error("channel error indicator wrong");

  edge_irq_c: cover property (edge_hit ##1 hw_irq ##[1:20] hw_ack);
  lost_c: cover property (hw_irq && edge_hit && !hw_ack ##1 lost_q);
  fw_c: cover property (fw_s ##1 diag_code == `CODE_UNAVAIL);

endmodule
`default_nettype wire

// File: logic/input_sync.sv
// three-stage synchroniser, a change counts when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module input_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // pins and synchronised levels
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            sync_out[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire
